// *** pofac_pkg.sv ***
// Package for the flow action comparator: register map, fields, commands
// Behaviour
// - Per-flow 64-bit masked header match
// - One shared mask, match value and range per flow
// - Optional range check on pointed byte
// - Commands 0, 1, 3: none, subtract, add
// - Command 2: minus latency plus path delay
// - Command 4: add time plus latency minus stored
// - Command 5: store local time in frame
// - Command 6: legacy store time and delay
// - Command 7: write nanoseconds to new location
// - Command 8: nanoseconds plus delay, both fields
// - Save-time bit pushes time to FIFO
// - Five-bit correction field offset
// - Six-bit time storage offset
// - Separate add and subtract asymmetry enables
// - Zero run; length zero disables it
// - Status-update bit flags modified byte
// - Stamp byte count and offset from SFD
// - Eight-bit new correction location
// - Flow needs enable and channel bit
// - Checksum source select bit
// - Two-bit signature address source
// - Group mask gates prior-stage group match
// - No protocol validation, header only
package pofac_pkg;
   localparam int NUM_FLOWS = 8;
   localparam int NUM_CHAN = 2;
   localparam int FLOW_W = 3;
   // Per-flow block: 16 words at 0x100 + flow*0x40
   localparam logic [11:0] FLOW_BASE = 12'h100;
   localparam int FLOW_STRIDE_SH = 6;
   localparam logic [11:0] MASK_LO = 12'h000;
   localparam logic [11:0] MASK_HI = 12'h004;
   localparam logic [11:0] COMMON = 12'h008;
   localparam logic [11:0] STATUS = 12'h00C;
   localparam logic [3:0] F_MATCH_LO = 4'h0;
   localparam logic [3:0] F_MATCH_HI = 4'h1;
   localparam logic [3:0] F_RANGE = 4'h2;
   localparam logic [3:0] F_ACTION = 4'h3;
   localparam logic [3:0] F_ZERO = 4'h4;
   localparam logic [3:0] F_STAMP = 4'h5;
   localparam logic [3:0] F_ENABLE = 4'h6;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [63:0] RESET_MASK = 64'h0000_0000_0000_0000;
   localparam int HDR_BYTES = 32;
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_SUB = 4'h1, CMD_PEER_LAT = 4'h2,
      CMD_ADD = 4'h3, CMD_SUB_ADD = 4'h4, CMD_STORE = 4'h5,
      CMD_LEGACY_P2P = 4'h6, CMD_NS = 4'h7, CMD_NS_P2P = 4'h8
   } pofac_cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, ST_EVAL = 3'b010, ST_DONE = 3'b100
   } pofac_state_t;
endpackage

// *** pofac_cfg_if.sv ***
// Carrier between the comparator and its per-flow configuration memory
`timescale 1ns/1ps
`default_nettype none
interface pofac_cfg_if;
   logic we;
   logic [2:0] flow;
   logic [3:0] word;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport ctrl(output we, flow, word, wdata, input rdata);
   modport mem(input we, flow, word, wdata, output rdata);
endinterface
`default_nettype wire

// *** pofac_flow_mem.sv ***
// Per-flow configuration store, registered read port
`timescale 1ns/1ps
`default_nettype none
module pofac_flow_mem
   import pofac_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   pofac_cfg_if.mem port
);
   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   logic [31:0] store [NUM_FLOWS*8];
   logic [5:0] idx;
   assign idx = {port.flow, port.word[2:0]};
   // Cleared on reset so that reading an unwritten word gives zero
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_FLOWS*8; i++) begin
            store[i] <= RESET_WORD;
         end
      end else if (port.we) begin
         store[idx] <= port.wdata;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         port.rdata <= RESET_WORD;
      end else begin
         port.rdata <= port.we ? port.wdata : store[idx];
      end
   end
endmodule
`default_nettype wire

// *** pofac_top.sv ***
// Flow action comparator: AHB-Lite registers, header match, action select
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pofac_top
   import pofac_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic frame_valid_i,
   input wire logic frame_chan_i,
   input wire logic [255:0] frame_hdr_i,
   input wire logic [NUM_FLOWS-1:0] prior_match_i,
   input wire logic [1:0] prior_group_i,
   output logic act_valid_o,
   output logic act_match_o,
   output logic [2:0] act_flow_o,
   output logic [3:0] act_cmd_o,
   output logic act_save_time_o,
   output logic [4:0] act_corr_off_o,
   output logic [5:0] act_store_off_o,
   output logic act_asym_add_o,
   output logic act_asym_sub_o,
   output logic act_zero_en_o,
   output logic [5:0] act_zero_off_o,
   output logic [3:0] act_zero_len_o,
   output logic act_mod_upd_o,
   output logic [2:0] act_mod_off_o,
   output logic [3:0] act_stamp_len_o,
   output logic [7:0] act_stamp_off_o,
   output logic [7:0] act_new_cf_o,
   output logic fifo_push_o,
   output logic chk_sel_o,
   output logic [1:0] sig_src_o
);
   // -------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------
   pofac_cfg_if cfg();
   pofac_flow_mem u_mem (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .port(cfg)
   );

   logic [63:0] header_match_mask;
   logic checksum_source_select;
   logic [1:0] signature_address_source;
   logic [NUM_FLOWS-1:0] flow_valid_enable;
   logic [NUM_FLOWS-1:0] flow_channel_select [NUM_CHAN];
   logic [NUM_FLOWS-1:0] match_seen;
   pofac_state_t state;
   logic [2:0] scan;
   logic wr_pend, rd_pend;
   logic [11:0] a_addr;

   function automatic logic is_flow(input logic [11:0] a);
      is_flow = (a >= FLOW_BASE) && (a < FLOW_BASE + 12'h200);
   endfunction
   function automatic logic [2:0] flow_of(input logic [11:0] a);
      logic [11:0] d;
      d = a - FLOW_BASE;
      flow_of = d[8:6];
   endfunction
   function automatic logic [3:0] word_of(input logic [11:0] a);
      word_of = a[5:2];
   endfunction

   logic take;
   assign take = hsel_i && hready_i && htrans_i[1] && (state == ST_IDLE);

   // Bus stalls one cycle per read; while the scan runs no transfer is taken
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         a_addr <= 12'h000;
         hreadyout_o <= 1'b1;
      end else begin
         wr_pend <= take && hwrite_i;
         rd_pend <= take && !hwrite_i;
         if (take) begin
            a_addr <= haddr_i;
         end
         hreadyout_o <= !(take && !hwrite_i);
      end
   end
   assign hresp_o = 1'b0;

   logic mem_wr;
   assign mem_wr = wr_pend && is_flow(a_addr)
      && (word_of(a_addr) <= F_ENABLE);

   always_comb begin
      cfg.we = mem_wr && (word_of(a_addr) != F_ENABLE);
      cfg.wdata = hwdata_i;
      if (state != ST_IDLE) begin
         cfg.flow = scan;
         cfg.word = F_ACTION;
      end else if (wr_pend || rd_pend) begin
         cfg.flow = flow_of(a_addr);
         cfg.word = word_of(a_addr);
      end else begin
         cfg.flow = flow_of(haddr_i);
         cfg.word = word_of(haddr_i);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         header_match_mask <= RESET_MASK;
         checksum_source_select <= 1'b0;
         signature_address_source <= 2'b00;
         flow_valid_enable <= '0;
         flow_channel_select[0] <= '0;
         flow_channel_select[1] <= '0;
      end else if (wr_pend) begin
         if (a_addr == MASK_LO) begin
            header_match_mask[31:0] <= hwdata_i;
         end else if (a_addr == MASK_HI) begin
            header_match_mask[63:32] <= hwdata_i;
         end else if (a_addr == COMMON) begin
            checksum_source_select <= hwdata_i[0];
            signature_address_source <= hwdata_i[2:1];
         end else if (mem_wr && word_of(a_addr) == F_ENABLE) begin
            flow_valid_enable[flow_of(a_addr)] <= hwdata_i[0];
            flow_channel_select[0][flow_of(a_addr)] <= hwdata_i[1];
            flow_channel_select[1][flow_of(a_addr)] <= hwdata_i[2];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_o <= RESET_WORD;
      end else if (rd_pend) begin
         if (a_addr == MASK_LO) begin
            hrdata_o <= header_match_mask[31:0];
         end else if (a_addr == MASK_HI) begin
            hrdata_o <= header_match_mask[63:32];
         end else if (a_addr == COMMON) begin
            hrdata_o <= {29'h0, signature_address_source,
               checksum_source_select};
         end else if (a_addr == STATUS) begin
            hrdata_o <= {24'h0, match_seen};
         end else if (is_flow(a_addr) && word_of(a_addr) == F_ENABLE) begin
            hrdata_o <= {29'h0, flow_channel_select[1][flow_of(a_addr)],
               flow_channel_select[0][flow_of(a_addr)],
               flow_valid_enable[flow_of(a_addr)]};
         end else if (is_flow(a_addr) && word_of(a_addr) < F_ENABLE) begin
            hrdata_o <= cfg.rdata;
         end else begin
            hrdata_o <= RESET_WORD;
         end
      end
   end

   // -------------------------------------------------------------
   // Matching: all flows compared in parallel, winner's action word read from memory
   // -------------------------------------------------------------
   // Match words are held in a register copy for parallel compare
   logic [63:0] match_val [NUM_FLOWS];
   logic [31:0] range_w [NUM_FLOWS];
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_FLOWS; i++) begin
            match_val[i] <= RESET_MASK;
            range_w[i] <= RESET_WORD;
         end
      end else if (mem_wr) begin
         if (word_of(a_addr) == F_MATCH_LO) begin
            match_val[flow_of(a_addr)][31:0] <= hwdata_i;
         end else if (word_of(a_addr) == F_MATCH_HI) begin
            match_val[flow_of(a_addr)][63:32] <= hwdata_i;
         end else if (word_of(a_addr) == F_RANGE) begin
            range_w[flow_of(a_addr)] <= hwdata_i;
         end
      end
   end

   logic [255:0] hdr;
   logic chan;
   logic [1:0] grp;
   logic [NUM_FLOWS-1:0] prior;
   logic [NUM_FLOWS-1:0] hit;
   // the masked match looks at the leading 8 header bytes; the range byte can be any of the 32
   genvar g;
   generate
      for (g = 0; g < NUM_FLOWS; g++) begin : gen_flow
         logic [7:0] fld;
         logic in_rng;
         assign fld = hdr[255 - 8*range_w[g][20:16] -: 8];
         assign in_rng = !range_w[g][24] ||
            (fld >= range_w[g][7:0] && fld <= range_w[g][15:8]);
         assign hit[g] = flow_valid_enable[g]
            && flow_channel_select[chan][g] && prior[g]
            && (((hdr[255:192] ^ match_val[g]) & header_match_mask)
               == 64'h0)
            && in_rng && ((range_w[g][26:25] & grp) != 2'b00);
      end
   endgenerate

   logic [2:0] win;
   logic any_hit;
   always_comb begin
      win = 3'h0;
      any_hit = 1'b0;
      for (int i = NUM_FLOWS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            win = 3'(i);
            any_hit = 1'b1;
         end
      end
   end

   logic [31:0] act_w;
   logic [1:0] rd_step;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         scan <= 3'h0;
         rd_step <= 2'h0;
         hdr <= '0;
         chan <= 1'b0;
         grp <= 2'b00;
         prior <= '0;
         act_w <= RESET_WORD;
         match_seen <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (frame_valid_i && !wr_pend && !rd_pend && !take) begin
                  hdr <= frame_hdr_i;
                  chan <= frame_chan_i;
                  grp <= prior_group_i;
                  prior <= prior_match_i;
                  rd_step <= 2'h0;
                  state <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               scan <= win;
               rd_step <= rd_step + 2'h1;
               if (rd_step == 2'h3) begin
                  act_w <= cfg.rdata;
                  match_seen <= match_seen | hit;
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Zero and stamp words are taken from the register copy
   logic [31:0] zw [NUM_FLOWS];
   logic [31:0] sw [NUM_FLOWS];
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NUM_FLOWS; i++) begin
            zw[i] <= RESET_WORD;
            sw[i] <= RESET_WORD;
         end
      end else if (mem_wr) begin
         if (word_of(a_addr) == F_ZERO) begin
            zw[flow_of(a_addr)] <= hwdata_i;
         end else if (word_of(a_addr) == F_STAMP) begin
            sw[flow_of(a_addr)] <= hwdata_i;
         end
      end
   end

   // -------------------------------------------------------------
   // Action outputs
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         act_valid_o <= 1'b0;
         act_match_o <= 1'b0;
         act_flow_o <= 3'h0;
         act_cmd_o <= CMD_NONE;
         act_save_time_o <= 1'b0;
         act_corr_off_o <= 5'h00;
         act_store_off_o <= 6'h00;
         act_asym_add_o <= 1'b0;
         act_asym_sub_o <= 1'b0;
         act_zero_en_o <= 1'b0;
         act_zero_off_o <= 6'h00;
         act_zero_len_o <= 4'h0;
         act_mod_upd_o <= 1'b0;
         act_mod_off_o <= 3'h0;
         act_stamp_len_o <= 4'h0;
         act_stamp_off_o <= 8'h00;
         act_new_cf_o <= 8'h00;
         fifo_push_o <= 1'b0;
      end else begin
         act_valid_o <= (state == ST_DONE);
         fifo_push_o <= 1'b0;
         if (state == ST_DONE) begin
            act_match_o <= any_hit;
            act_flow_o <= scan;
            act_cmd_o <= any_hit && act_w[3:0] <= CMD_NS_P2P
               ? act_w[3:0] : CMD_NONE;
            act_save_time_o <= any_hit && act_w[4];
            fifo_push_o <= any_hit && act_w[4];
            act_corr_off_o <= act_w[12:8];
            act_store_off_o <= act_w[21:16];
            act_asym_add_o <= any_hit && act_w[24];
            act_asym_sub_o <= any_hit && act_w[25];
            act_zero_en_o <= any_hit && zw[scan][11:8] != 4'h0;
            act_zero_off_o <= zw[scan][5:0];
            act_zero_len_o <= zw[scan][11:8];
            act_mod_upd_o <= any_hit && zw[scan][16];
            act_mod_off_o <= zw[scan][22:20];
            act_stamp_len_o <= sw[scan][3:0];
            act_stamp_off_o <= sw[scan][15:8];
            act_new_cf_o <= sw[scan][23:16];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chk_sel_o <= 1'b0;
         sig_src_o <= 2'b00;
      end else begin
         chk_sel_o <= checksum_source_select;
         sig_src_o <= signature_address_source;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   chk_push_save: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) fifo_push_o |-> act_valid_o && act_save_time_o)
      else $error("fifo push without save");
   chk_zero_len: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) act_valid_o && act_zero_len_o == 4'h0
      |-> !act_zero_en_o)
      else $error("zero run enabled with length zero");
   chk_cmd_range: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) act_valid_o |-> act_cmd_o <= CMD_NS_P2P)
      else $error("illegal command");
   chk_nomatch_nop: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) act_valid_o && !act_match_o
      |-> act_cmd_o == CMD_NONE && !fifo_push_o)
      else $error("action without match");
   chk_flow_enable: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) state == ST_DONE && any_hit
      |-> flow_valid_enable[win])
      else $error("disabled flow matched");
   chk_group_gate: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) state == ST_DONE && grp == 2'b00 |=> !act_match_o)
      else $error("match without group");
   chk_eval_len: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) $rose(state == ST_EVAL) |-> ##4 state == ST_DONE
      ##1 act_valid_o)
      else $error("evaluation length wrong");
   chk_sig_src: assert property (@(posedge ref_clk_i) disable iff
      (!rst_b_i) ##1 sig_src_o == $past(signature_address_source))
      else $error("signature source stale");
endmodule
`default_nettype wire

// *** pofac_partner.sv ***
// Far-side model: earlier comparator stages offering one frame at a time
`timescale 1ns/1ps
`default_nettype none
module pofac_partner
   import pofac_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic act_valid_i,
   input wire logic fifo_push_i,
   output logic frame_valid_o,
   output logic frame_chan_o,
   output logic [255:0] frame_hdr_o,
   output logic [NUM_FLOWS-1:0] prior_match_o,
   output logic [1:0] prior_group_o
);
   initial begin
      frame_valid_o = 1'h0;
      frame_chan_o = 1'h0;
      frame_hdr_o = '0;
      prior_match_o = '0;
      prior_group_o = 2'h0;
   end

   // Frame is taken at one edge; afterwards the lines carry the inverse
   // so a design that reads them late sees junk, not the old value
   task automatic send_frame(input logic ch, input logic [255:0] hdr,
         input logic [NUM_FLOWS-1:0] pm, input logic [1:0] grp,
         output logic seen, output logic push);
      int n;
      frame_valid_o <= 1'h1;
      frame_chan_o <= ch;
      frame_hdr_o <= hdr;
      prior_match_o <= pm;
      prior_group_o <= grp;
      @(posedge ref_clk_i);
      frame_valid_o <= 1'h0;
      frame_chan_o <= ~ch;
      frame_hdr_o <= ~hdr;
      prior_match_o <= ~pm;
      prior_group_o <= ~grp;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (act_valid_i !== 1'h1 && n < 40);
      seen = act_valid_i;
      push = fifo_push_i;
   endtask
endmodule
`default_nettype wire

// *** pofac_tb_top.sv ***
// Self-checking testbench for the flow action comparator
`timescale 1ns/1ps
`default_nettype none
module pofac_tb_top
   import pofac_pkg::*;
;
   typedef struct packed {
      logic ch;
      logic [7:0] b0, b1, b4, b7, pm;
      logic [1:0] grp;
      logic em;
      logic [2:0] ef;
   } pofac_row_t;

   logic ref_clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic hsel_i = 1'h0;
   logic [11:0] haddr_i = 12'h000;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'h0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0000_0000;
   logic hready_i;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, frame_valid_i, frame_chan_i;
   logic [255:0] frame_hdr_i;
   logic [NUM_FLOWS-1:0] prior_match_i;
   logic [1:0] prior_group_i, sig_src_o;
   logic act_valid_o, act_match_o, act_save_time_o, act_asym_add_o;
   logic act_asym_sub_o, act_zero_en_o, act_mod_upd_o, fifo_push_o;
   logic chk_sel_o;
   logic [2:0] act_flow_o, act_mod_off_o;
   logic [3:0] act_cmd_o, act_zero_len_o, act_stamp_len_o;
   logic [4:0] act_corr_off_o;
   logic [5:0] act_store_off_o, act_zero_off_o;
   logic [7:0] act_stamp_off_o, act_new_cf_o;
   logic [63:0] act_now;
   logic [31:0] cfg_act [NUM_FLOWS] = '{default: 32'h0000_0000};
   logic [31:0] cfg_zero [NUM_FLOWS] = '{default: 32'h0000_0000};
   logic [31:0] cfg_stamp [NUM_FLOWS] = '{default: 32'h0000_0000};
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;

   assign hready_i = hreadyout_o;
   assign act_now = {7'h00, act_match_o, act_flow_o, act_cmd_o,
      act_save_time_o, act_corr_off_o, act_store_off_o, act_asym_add_o,
      act_asym_sub_o, act_zero_en_o, act_zero_off_o, act_zero_len_o,
      act_mod_upd_o, act_mod_off_o, act_stamp_len_o, act_stamp_off_o,
      act_new_cf_o};

   always #5 ref_clk_i = ~ref_clk_i;

   pofac_top DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .frame_valid_i(frame_valid_i),
      .frame_chan_i(frame_chan_i), .frame_hdr_i(frame_hdr_i),
      .prior_match_i(prior_match_i), .prior_group_i(prior_group_i),
      .act_valid_o(act_valid_o), .act_match_o(act_match_o),
      .act_flow_o(act_flow_o), .act_cmd_o(act_cmd_o),
      .act_save_time_o(act_save_time_o), .act_corr_off_o(act_corr_off_o),
      .act_store_off_o(act_store_off_o), .act_asym_add_o(act_asym_add_o),
      .act_asym_sub_o(act_asym_sub_o), .act_zero_en_o(act_zero_en_o),
      .act_zero_off_o(act_zero_off_o), .act_zero_len_o(act_zero_len_o),
      .act_mod_upd_o(act_mod_upd_o), .act_mod_off_o(act_mod_off_o),
      .act_stamp_len_o(act_stamp_len_o), .act_stamp_off_o(act_stamp_off_o),
      .act_new_cf_o(act_new_cf_o), .fifo_push_o(fifo_push_o),
      .chk_sel_o(chk_sel_o), .sig_src_o(sig_src_o));

   pofac_partner far (.ref_clk_i(ref_clk_i), .act_valid_i(act_valid_o),
      .fifo_push_i(fifo_push_o), .frame_valid_o(frame_valid_i),
      .frame_chan_o(frame_chan_i), .frame_hdr_o(frame_hdr_i),
      .prior_match_o(prior_match_i), .prior_group_o(prior_group_i));

   // ----------------------------------------------------------------
   // Bus, compare and frame tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Unmatched frames carry flow 0's stored action fields, so compare only seen, push and match
   task automatic check_act(input logic [63:0] got, input logic [63:0] exp,
         input logic [63:0] m);
      comparisons++;
      if ((got & m) !== (exp & m)) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [11:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel_i <= 1'h1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= wr;
      hsize_i <= 3'h2;
      do @(posedge ref_clk_i); while (hready_i !== 1'h1);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge ref_clk_i); while (hready_i !== 1'h1);
      rd = hrdata_o;
   endtask

   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'h1, a, d, rd);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'h0, a, 32'h0000_0000, rd);
      check_reg(rd, exp);
      check_reg({31'h0, hresp_o}, 32'h0000_0000);
   endtask

   function automatic logic [11:0] flow_addr(input int f,
         input logic [3:0] w);
      return FLOW_BASE + (12'(f) << FLOW_STRIDE_SH) + {6'h00, w, 2'h0};
   endfunction

   task automatic set_flow(input int f, input logic [3:0] w,
         input logic [31:0] d);
      if (w == F_ACTION) cfg_act[f] = d;
      if (w == F_ZERO) cfg_zero[f] = d;
      if (w == F_STAMP) cfg_stamp[f] = d;
      wr32(flow_addr(f, w), d);
   endtask

   function automatic logic [63:0] exp_act(input logic m,
         input logic [2:0] f);
      logic [31:0] a, z, s;
      a = cfg_act[f];
      z = cfg_zero[f];
      s = cfg_stamp[f];
      return {5'h00, 1'h1, m & a[4], m, f, a[3:0], a[4], a[12:8],
         a[21:16], a[24], a[25], |z[11:8], z[5:0], z[11:8], z[16],
         z[22:20], s[3:0], s[15:8], s[23:16]};
   endfunction

   task automatic run_row(input pofac_row_t r);
      logic seen, push;
      logic [255:0] h;
      h = {32{8'hA5}};
      h[255:248] = r.b0;
      h[247:240] = r.b1;
      h[223:216] = r.b4;
      h[199:192] = r.b7;
      far.send_frame(r.ch, h, r.pm, r.grp, seen, push);
      check_act({5'h00, seen, push, act_now[56:0]}, exp_act(r.em, r.ef),
         r.em ? '1 : 64'h0700_0000_0000_0000);
   endtask

   // ----------------------------------------------------------------
   // Case table and main sequence
   // ----------------------------------------------------------------
   logic [39:0] setup [14] = '{
      {4'h1, F_MATCH_HI, 32'h12EE_0000}, {4'h1, F_MATCH_LO, 32'h0000_0034},
      {4'h1, F_RANGE, 32'h0200_0000}, {4'h1, F_ACTION, 32'h0105_0A13},
      {4'h1, F_ZERO, 32'h0051_0304}, {4'h1, F_STAMP, 32'h0024_1808},
      {4'h1, F_ENABLE, 32'h0000_0003}, {4'h2, F_MATCH_HI, 32'h1200_0000},
      {4'h2, F_MATCH_LO, 32'h0000_0034}, {4'h2, F_RANGE, 32'h0704_2010},
      {4'h2, F_ACTION, 32'h0200_0002}, {4'h2, F_ZERO, 32'h0000_0000},
      {4'h2, F_STAMP, 32'h0030_2A0A}, {4'h2, F_ENABLE, 32'h0000_0005}};

   pofac_row_t rows [11] = '{
      '{1'h0, 8'h12, 8'h77, 8'h00, 8'h34, 8'h02, 2'h1, 1'h1, 3'h1},
      '{1'h0, 8'h12, 8'h00, 8'h00, 8'h35, 8'h02, 2'h1, 1'h0, 3'h0},
      '{1'h0, 8'h12, 8'h00, 8'h00, 8'h34, 8'h00, 2'h1, 1'h0, 3'h0},
      '{1'h0, 8'h12, 8'h00, 8'h00, 8'h34, 8'h02, 2'h2, 1'h0, 3'h0},
      '{1'h1, 8'h12, 8'h00, 8'h10, 8'h34, 8'h04, 2'h2, 1'h1, 3'h2},
      '{1'h1, 8'h12, 8'h00, 8'h20, 8'h34, 8'h04, 2'h1, 1'h1, 3'h2},
      '{1'h1, 8'h12, 8'h00, 8'h21, 8'h34, 8'h04, 2'h2, 1'h0, 3'h0},
      '{1'h1, 8'h12, 8'h00, 8'h0F, 8'h34, 8'h04, 2'h2, 1'h0, 3'h0},
      '{1'h0, 8'h12, 8'h00, 8'h15, 8'h34, 8'h04, 2'h1, 1'h0, 3'h0},
      '{1'h1, 8'h12, 8'h00, 8'h15, 8'h34, 8'h06, 2'h3, 1'h1, 3'h2},
      '{1'h1, 8'h12, 8'h00, 8'h15, 8'h34, 8'h06, 2'h0, 1'h0, 3'h0}};

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      pofac_row_t r;
      logic [31:0] a;
      int i;
      repeat (5) @(posedge ref_clk_i);
      rst_b_i <= 1'h1;
      check_reg({29'h0, act_valid_o, hreadyout_o, hresp_o}, 32'h0000_0002);
      rd_chk(MASK_LO, RESET_WORD);
      rd_chk(flow_addr(0, F_ACTION), RESET_WORD);
      for (i = 0; i < 8; i++) begin
         wr32(COMMON, 32'(i));
         rd_chk(COMMON, 32'(i));
         check_reg({29'h0, sig_src_o, chk_sel_o}, 32'(i));
      end
      wr32(12'h084, 32'hFFFF_FFFF);
      rd_chk(12'h084, 32'h0000_0000);
      wr32(MASK_HI, 32'hFF00_0000);
      wr32(MASK_LO, 32'h0000_00FF);
      rd_chk(MASK_HI, 32'hFF00_0000);
      foreach (setup[k]) set_flow(int'(setup[k][39:36]), setup[k][35:32],
         setup[k][31:0]);
      foreach (rows[k]) run_row(rows[k]);
      // Status is sticky and read only: a write must not clear it
      rd_chk(STATUS, 32'h0000_0006);
      wr32(STATUS, 32'hFFFF_FFFF);
      rd_chk(STATUS, 32'h0000_0006);
      for (i = 0; i <= 8; i++) begin
         a = {6'h00, 2'(i), 2'h0, 6'(i * 7), 3'h0, 5'(31 - i), 3'h0, 1'(i),
            4'(i)};
         set_flow(1, F_ACTION, a);
         set_flow(1, F_ZERO, {9'h000, 3'(i), 3'h0, 1'(i + 1), 4'h0, 4'(i),
            2'h0, 6'(63 - i)});
         set_flow(1, F_STAMP, {8'h00, 8'(i * 17), 8'(255 - i), 4'h0,
            4'(15 - i)});
         rd_chk(flow_addr(1, F_ACTION), a);
         run_row(rows[0]);
      end
      set_flow(1, F_ENABLE, 32'h0000_0000);
      r = rows[0];
      r.em = 1'h0;
      run_row(r);
      set_flow(1, F_ENABLE, 32'h0000_0007);
      r = rows[9];
      r.ef = 3'h1;
      run_row(r);
      // Reset in mid-run must clear outputs and the flow store
      rst_b_i <= 1'h0;
      repeat (2) @(posedge ref_clk_i);
      check_reg({29'h0, act_match_o, chk_sel_o, hreadyout_o}, 32'h0000_0001);
      rst_b_i <= 1'h1;
      rd_chk(flow_addr(1, F_ACTION), RESET_WORD);
      give_verdict();
   end
endmodule
`default_nettype wire
